//--- common/oss_regs.svh
/*
 * Constants of the octal serial switch control block: bit positions,
 * reset values and timing counts.
 * Assumes a 50 MHz system clock.
 */
`ifndef OSS_REGS_SVH
`define OSS_REGS_SVH

`define OSS_OUT_CNT       8
`define OSS_MSB           7
`define OSS_OUT5_BIT      4
`define OSS_OUT6_BIT      5
`define OSS_WORD_RST      8'h00
`define OSS_SYNC_LOW_RST  3'h0
`define OSS_SYNC_HIGH_RST 3'h7
`define OSS_CLK_MHZ       50
`define OSS_FAULT_DLY_US  100
`define OSS_FAULT_CYC     (`OSS_FAULT_DLY_US * `OSS_CLK_MHZ)

`endif

//--- common/oss_pkg.sv
/*
 * Types of the octal serial switch control block.
 * Assumes the constants of oss_regs.svh.
 */
package oss_pkg;

   // system-domain state of the core
   typedef struct packed {
      logic [2:0] cs_sy;
      logic [2:0] en_sy;
      logic [2:0] d5_sy;
      logic [2:0] d6_sy;
      logic       cs_st;
      logic       en_st;
      logic       d5_st;
      logic       d6_st;
      logic [7:0] cmd;
      logic [7:0] status_hold;
      logic [7:0] drive;
      logic       link_clr;
   } oss_core_t;

   // serial-clock falling edge state
   typedef struct packed {
      logic       seen;
   } oss_neg_t;

   // serial-clock rising edge state
   typedef struct packed {
      logic       seen;
      logic       dout;
   } oss_pos_t;

endpackage

//--- common/oss_link_if.sv
/*
 * Carrier between the core and the serial link logic.
 * Assumes status_word and link_clr are held steady while the link clock runs.
 */
`timescale 1ns/1ps
`default_nettype none
interface oss_link_if;
   logic [7:0] status_word;
   logic [7:0] shift_word;
   logic       link_clr;
   modport core (output status_word, output link_clr, input shift_word);
   modport link (input status_word, input link_clr, output shift_word);
endinterface
`default_nettype wire

//--- rtl/oss_fault_filter.sv
/*
 * One output's fault persistence filter: synchroniser plus delay counter.
 * Assumes an asynchronous fault level from the analog side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "oss_regs.svh"
module oss_fault_filter #(
   parameter int PERSIST = `OSS_FAULT_CYC
) (
   input  wire logic clk,        // system clock
   input  wire logic sys_rst,    // synchronous reset
   input  wire logic fault_pin,  // raw fault level
   input  wire logic enable,     // synchronised enable
   output var  logic fault_flag  // persisted fault
);
   localparam int CNT_W = $clog2(PERSIST + 1);

   typedef struct packed {
      logic [2:0]       sy;
      logic             st;
      logic [CNT_W-1:0] cnt;
      logic             flag;
   } oss_flt_t;

   oss_flt_t flt_reg;
   oss_flt_t flt_next;

   always_comb begin
      flt_next = flt_reg;
      flt_next.sy = {flt_reg.sy[1:0], fault_pin};
      if (flt_reg.sy[1] == flt_reg.sy[2]) begin
         flt_next.st = flt_reg.sy[2];
      end
      if (!enable || !flt_reg.st) begin
         flt_next.cnt = '0;
         flt_next.flag = 1'b0;
      end else if (flt_reg.cnt == CNT_W'(PERSIST - 1)) begin
         flt_next.flag = 1'b1;
      end else begin
         flt_next.cnt = flt_reg.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flt_reg <= '0;
      end else begin
         flt_reg <= flt_next;
      end
   end

   assign fault_flag = flt_reg.flag;

   AST_FLT_PERSIST: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(flt_reg.flag) |-> $past(flt_reg.cnt) == CNT_W'(PERSIST - 1) && $past(flt_reg.st))
      else $error("fault flag set before persistence delay");
   AST_FLT_DISABLE: assert property (@(posedge clk) disable iff (sys_rst)
      !enable |=> !flt_reg.flag)
      else $error("fault flag set while disabled");
   AST_FLT_NORMAL: assert property (@(posedge clk) disable iff (sys_rst)
      !flt_reg.st |=> !flt_reg.flag ##1 !flt_reg.flag || flt_reg.st)
      else $error("fault flag set for healthy output");
   COV_FLT_SET: cover property (@(posedge clk) disable iff (sys_rst) $rose(flt_reg.flag));
endmodule
`default_nettype wire

//--- rtl/oss_spi_link.sv
/*
 * Serial shift logic on the host's serial clock.
 * Assumes select and data change only while the serial clock is low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "oss_regs.svh"
module oss_spi_link (
   input  wire logic  spi_sclk,        // serial clock from host
   input  wire logic  spi_cs_n,        // chip select, active low
   input  wire logic  serial_cmd_in,   // serial data in
   oss_link_if.link   lk,              // core side
   output var  logic  serial_data_out  // serial data out value
);
   oss_pkg::oss_neg_t neg_reg;
   oss_pkg::oss_neg_t neg_next;
   oss_pkg::oss_pos_t pos_reg;
   oss_pkg::oss_pos_t pos_next;
   logic [7:0]        sr_reg;
   logic [7:0]        sr_next;

   // first falling edge takes the frozen status word above the new bit
   always_comb begin
      neg_next = neg_reg;
      neg_next.seen = 1'b1;
      if (!neg_reg.seen) begin
         sr_next = {lk.status_word[6:0], serial_cmd_in};
      end else begin
         sr_next = {sr_reg[6:0], serial_cmd_in};
      end
   end

   // select high or power-on clear holds the frame flags cleared
   always_ff @(negedge spi_sclk or posedge spi_cs_n or posedge lk.link_clr) begin
      if (spi_cs_n || lk.link_clr) begin
         neg_reg <= '0;
      end else begin
         neg_reg <= neg_next;
      end
   end

   always_ff @(negedge spi_sclk or posedge lk.link_clr) begin
      if (lk.link_clr) begin
         sr_reg <= `OSS_WORD_RST;
      end else if (!spi_cs_n) begin
         sr_reg <= sr_next;
      end
   end

   always_comb begin
      pos_next = pos_reg;
      pos_next.seen = 1'b1;
      if (!pos_reg.seen) begin
         pos_next.dout = lk.status_word[`OSS_MSB];
      end else begin
         pos_next.dout = sr_reg[`OSS_MSB];
      end
   end

   always_ff @(posedge spi_sclk or posedge spi_cs_n or posedge lk.link_clr) begin
      if (spi_cs_n || lk.link_clr) begin
         pos_reg <= '0;
      end else begin
         pos_reg <= pos_next;
      end
   end

   assign lk.shift_word = sr_reg;
   assign serial_data_out = pos_reg.dout;

   AST_DO_FIRST: assert property (@(posedge spi_sclk) disable iff (spi_cs_n)
      !pos_reg.seen ##1 pos_reg.seen |-> serial_data_out == lk.status_word[`OSS_MSB])
      else $error("first clock did not present output 8 status");
   AST_SR_SHIFT: assert property (@(negedge spi_sclk) disable iff (spi_cs_n)
      neg_reg.seen |=> sr_reg[7:1] == $past(sr_reg[6:0]) && sr_reg[0] == $past(serial_cmd_in))
      else $error("shift register did not shift in order");
   COV_FULL_BYTE: cover property (@(negedge spi_sclk) disable iff (spi_cs_n)
      neg_reg.seen [*8]);
endmodule
`default_nettype wire

//--- rtl/oss_switch_ctrl.sv
/*
 * Control logic of an eight-output serial power switch: command latch,
 * enable gating, direct command inputs and fault status capture.
 * Assumes sys_rst is the power-on reset of the logic supply and that the
 * host keeps the serial clock low whenever chip select changes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "oss_regs.svh"
module oss_switch_ctrl #(
   parameter int FAULT_CYCLES = `OSS_FAULT_CYC
) (
   input  wire logic       clk,              // system clock, 50 MHz
   input  wire logic       sys_rst,          // synchronous reset, high
   input  wire logic       spi_sclk,         // serial clock from host
   input  wire logic       spi_cs_n,         // chip select, active low
   input  wire logic       serial_cmd_in,    // serial data in
   output var  logic       serial_data_out,  // serial data out value
   output var  logic       serial_data_oe,   // serial data out enable
   input  wire logic       direct_cmd_five,  // direct command, output 5
   input  wire logic       direct_cmd_six,   // direct command, output 6
   input  wire logic       enable_in,        // output enable pin
   input  wire logic [7:0] load_fault,       // raw fault level per output
   output var  logic [7:0] switch_drive,     // gate drive per output
   output var  logic [7:0] fault_status      // persisted fault per output
);
   //----------------------------------------
   // state
   //----------------------------------------
   oss_pkg::oss_core_t core_reg;
   oss_pkg::oss_core_t core_next;
   logic [7:0]         fault_flt;
   logic               cs_rise;
   logic [7:0]         pwm_bits;

   oss_link_if lk ();

   //----------------------------------------
   // serial link and fault filters
   //----------------------------------------
   oss_spi_link u_link (
      .spi_sclk        (spi_sclk),
      .spi_cs_n        (spi_cs_n),
      .serial_cmd_in   (serial_cmd_in),
      .lk              (lk.link),
      .serial_data_out (serial_data_out)
   );

   genvar gi;
   generate
      for (gi = 0; gi < `OSS_OUT_CNT; gi++) begin : g_flt
         oss_fault_filter #(
            .PERSIST    (FAULT_CYCLES)
         ) u_flt (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .fault_pin  (load_fault[gi]),
            .enable     (core_reg.en_st),
            .fault_flag (fault_flt[gi])
         );
      end
   endgenerate

   //----------------------------------------
   // next state
   //----------------------------------------
   always_comb begin
      core_next = core_reg;
      core_next.link_clr = 1'b0;
      core_next.cs_sy = {core_reg.cs_sy[1:0], spi_cs_n};
      core_next.en_sy = {core_reg.en_sy[1:0], enable_in};
      core_next.d5_sy = {core_reg.d5_sy[1:0], direct_cmd_five};
      core_next.d6_sy = {core_reg.d6_sy[1:0], direct_cmd_six};
      if (core_reg.cs_sy[1] == core_reg.cs_sy[2]) begin
         core_next.cs_st = core_reg.cs_sy[2];
      end
      if (core_reg.en_sy[1] == core_reg.en_sy[2]) begin
         core_next.en_st = core_reg.en_sy[2];
      end
      if (core_reg.d5_sy[1] == core_reg.d5_sy[2]) begin
         core_next.d5_st = core_reg.d5_sy[2];
      end
      if (core_reg.d6_sy[1] == core_reg.d6_sy[2]) begin
         core_next.d6_st = core_reg.d6_sy[2];
      end
      // status follows the filters until select falls, then stays frozen
      if (core_reg.cs_st) begin
         core_next.status_hold = fault_flt;
      end
      // shift word is still while select is high, so it crosses as a bus
      if (cs_rise) begin
         core_next.cmd = lk.shift_word;
      end
      if (core_reg.en_st) begin
         core_next.drive = core_reg.cmd | pwm_bits;
      end else begin
         core_next.drive = `OSS_WORD_RST;
      end
   end

   always_comb begin
      cs_rise = !core_reg.cs_st && core_reg.cs_sy[1] && core_reg.cs_sy[2];
      pwm_bits = `OSS_WORD_RST;
      pwm_bits[`OSS_OUT5_BIT] = core_reg.d5_st;
      pwm_bits[`OSS_OUT6_BIT] = core_reg.d6_st;
   end

   //----------------------------------------
   // registers
   //----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         core_reg <= '0;
         core_reg.cs_sy <= `OSS_SYNC_HIGH_RST;
         core_reg.cs_st <= 1'b1;
         core_reg.en_sy <= `OSS_SYNC_LOW_RST;
         core_reg.cmd <= `OSS_WORD_RST;
         core_reg.link_clr <= 1'b1;
      end else begin
         core_reg <= core_next;
      end
   end

   //----------------------------------------
   // outputs
   //----------------------------------------
   assign lk.status_word = core_reg.status_hold;
   assign lk.link_clr = core_reg.link_clr;
   assign switch_drive = core_reg.drive;
   assign fault_status = core_reg.status_hold;
   // enable must follow select without any serial clock edge
   assign serial_data_oe = !spi_cs_n;

   //----------------------------------------
   // checks
   //----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_DRIVE_OFF: assert property (
      !core_reg.en_st |=> switch_drive == `OSS_WORD_RST)
      else $error("driver on while disabled");
   AST_RESUME: assert property (
      core_reg.en_st && !cs_rise |=> (switch_drive & core_reg.cmd) == core_reg.cmd)
      else $error("commanded output not driven while enabled");
   AST_PWM_OR: assert property (
      core_reg.en_st && (core_reg.d5_st || core_reg.cmd[`OSS_OUT5_BIT])
      |=> switch_drive[`OSS_OUT5_BIT])
      else $error("output five not ORed with direct input");
   AST_PWM_SIX: assert property (
      core_reg.en_st && !core_reg.d6_st && !core_reg.cmd[`OSS_OUT6_BIT]
      |=> !switch_drive[`OSS_OUT6_BIT])
      else $error("output six on without command");
   AST_CMD_HOLD: assert property (
      !cs_rise |=> core_reg.cmd == $past(core_reg.cmd))
      else $error("command latch changed outside select rise");
   AST_CMD_LOAD: assert property (
      cs_rise |=> core_reg.cmd == $past(lk.shift_word) ##1
      (!$past(core_reg.en_st) || (switch_drive & $past(core_reg.cmd)) == $past(core_reg.cmd)))
      else $error("command latch not loaded at select rise");
   AST_STATUS_FROZEN: assert property (
      !core_reg.cs_st ##1 !core_reg.cs_st |-> $stable(core_reg.status_hold))
      else $error("status changed during a frame");
   AST_RESET_OFF: assert property (
      $fell(sys_rst) |-> switch_drive == `OSS_WORD_RST && core_reg.cmd == `OSS_WORD_RST)
      else $error("outputs not off after reset");
   AST_LINK_CLR: assert property (
      $fell(sys_rst) |-> lk.link_clr)
      else $error("shift word not cleared by reset");
   AST_DRIVE_SERIAL: assert property (
      core_reg.en_st && !core_reg.d5_st && !core_reg.d6_st |=> switch_drive == $past(core_reg.cmd))
      else $error("drive differs from serial command");
   AST_STATUS_TRACK: assert property (
      core_reg.cs_st |=> fault_status == $past(fault_flt))
      else $error("status not following fault filters");
   AST_STATUS_OFF: assert property (
      !core_reg.en_st ##1 core_reg.cs_st |=> fault_status == `OSS_WORD_RST)
      else $error("fault reported while disabled");

   COV_FRAME: cover property (cs_rise && lk.shift_word != `OSS_WORD_RST);
   COV_PWM: cover property (core_reg.en_st && core_reg.d5_st ##1 switch_drive[`OSS_OUT5_BIT]);
   COV_RESUME: cover property ($rose(core_reg.en_st) ##2 switch_drive != `OSS_WORD_RST);
endmodule
`default_nettype wire

//--- tb/oss_host_model.sv
/*
 * Host-side serial master model driving the octal switch control block.
 * Assumes the bench calls one task at a time; times are plain delays.
 */
`timescale 1ns/1ps
`default_nettype none
module oss_host_model (
   output var  logic spi_sclk,         // serial clock to device
   output var  logic spi_cs_n,         // chip select, active low
   output var  logic serial_cmd_in,    // serial data to device
   input  wire logic serial_data_out,  // serial data from device
   input  wire logic serial_data_oe    // data out enable from device
);
   // ----------------------------------------
   // idle levels
   // ----------------------------------------
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      serial_cmd_in = 1'b0;
   end

   // ----------------------------------------
   // sixteen-bit frame, 30 ns clock; last byte becomes the command
   // ----------------------------------------
   task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic oe_all);
      int i;
      rx = 16'h0000;
      oe_all = 1'b1;
      spi_cs_n = 1'b0;
      #120;
      for (i = 15; i >= 0; i--) begin
         serial_cmd_in = tx[i];
         #10 spi_sclk = 1'b1;
         #12 rx[i] = serial_data_out;
         oe_all = oe_all & serial_data_oe;
         #3 spi_sclk = 1'b0;
         #5;
      end
      #60 spi_cs_n = 1'b1;
      serial_cmd_in = ~serial_cmd_in;
      #200;
   endtask

   // deliberate clock and data activity while deselected
   task automatic noise();
      int i;
      for (i = 0; i < 8; i++) begin
         serial_cmd_in = ~serial_cmd_in;
         #15 spi_sclk = 1'b1;
         #15 spi_sclk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
 * Self-checking bench of the octal switch control block.
 * Assumes oss_host_model plays the serial master on its own timing.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int FAULT_CYC = 8;
   localparam int PWM_HALF  = 12500;
   logic        clk;
   logic        sys_rst;
   logic        spi_sclk;
   logic        spi_cs_n;
   logic        serial_cmd_in;
   logic        serial_data_out;
   logic        serial_data_oe;
   logic        direct_cmd_five;
   logic        direct_cmd_six;
   logic        enable_in;
   logic [7:0]  load_fault;
   logic [7:0]  switch_drive;
   logic [7:0]  fault_status;
   logic [15:0] rx;
   logic        oe_all;
   int          mismatches;
   int          total_checks;

   initial clk = 1'b0;
   always #10 clk = ~clk;

   oss_switch_ctrl #(.FAULT_CYCLES(FAULT_CYC)) i_oss_switch_ctrl (
      .clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .serial_cmd_in(serial_cmd_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe), .direct_cmd_five(direct_cmd_five),
      .direct_cmd_six(direct_cmd_six), .enable_in(enable_in), .load_fault(load_fault),
      .switch_drive(switch_drive), .fault_status(fault_status)
   );

   oss_host_model i_oss_host_model (
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .serial_cmd_in(serial_cmd_in),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // bounded poll of drive (sel 0) or status (sel 1)
   task automatic wait_for(input string name, input bit sel, input logic [7:0] exp);
      logic [7:0] seen;
      int n;
      seen = 8'h00;
      for (n = 0; n < 60; n++) begin
         seen = sel ? fault_status : switch_drive;
         if (seen === exp) break;
         step(1);
      end
      check(name, seen, exp);
      if (seen !== exp) finish_test();
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      step(3);
      check("drive in reset", switch_drive, 8'h00);
      check("status in reset", fault_status, 8'h00);
      check("oe idle", {7'h00, serial_data_oe}, 8'h00);
      sys_rst = 1'b0;
      step(2);
      check("drive after reset", switch_drive, 8'h00);
   endtask

   task automatic t_frame();
      load_fault = 8'h81;
      wait_for("fault word", 1'b1, 8'h81);
      i_oss_host_model.frame(16'h5AA5, rx, oe_all);
      check("status out", rx[15:8], 8'h81);
      check("pass through", rx[7:0], 8'h5A);
      check("oe in frame", {7'h00, oe_all}, 8'h01);
      check("oe after frame", {7'h00, serial_data_oe}, 8'h00);
      wait_for("latch a5", 1'b0, 8'hA5);
      i_oss_host_model.frame(16'h0F3C, rx, oe_all);
      check("pass through 2", rx[7:0], 8'h0F);
      wait_for("latch 3c", 1'b0, 8'h3C);
      load_fault = 8'h00;
      wait_for("fault gone", 1'b1, 8'h00);
   endtask

   task automatic t_persist();
      load_fault = 8'h04;
      step(FAULT_CYC / 2);
      load_fault = 8'h00;
      step(FAULT_CYC * 3);
      check("short pulse", fault_status, 8'h00);
      load_fault = 8'h04;
      step(FAULT_CYC);
      check("not yet", fault_status, 8'h00);
      wait_for("persisted", 1'b1, 8'h04);
      load_fault = 8'h00;
      wait_for("cleared", 1'b1, 8'h00);
   endtask

   task automatic t_enable();
      load_fault = 8'h10;
      wait_for("fault on", 1'b1, 8'h10);
      enable_in = 1'b0;
      wait_for("drive off", 1'b0, 8'h00);
      wait_for("status off", 1'b1, 8'h00);
      enable_in = 1'b1;
      wait_for("drive back", 1'b0, 8'h3C);
      load_fault = 8'h00;
      wait_for("fault gone", 1'b1, 8'h00);
   endtask

   task automatic t_direct();
      i_oss_host_model.frame(16'h0000, rx, oe_all);
      wait_for("serial off", 1'b0, 8'h00);
      direct_cmd_five = 1'b1;
      wait_for("five direct", 1'b0, 8'h10);
      step(PWM_HALF);
      direct_cmd_five = 1'b0;
      direct_cmd_six = 1'b1;
      wait_for("six direct", 1'b0, 8'h20);
      step(PWM_HALF);
      direct_cmd_six = 1'b0;
      wait_for("both low", 1'b0, 8'h00);
      i_oss_host_model.frame(16'h0020, rx, oe_all);
      direct_cmd_five = 1'b1;
      wait_for("or of both", 1'b0, 8'h30);
      step(PWM_HALF);
      direct_cmd_five = 1'b0;
      wait_for("serial six", 1'b0, 8'h20);
   endtask

   task automatic t_noise();
      i_oss_host_model.noise();
      step(10);
      check("drive kept", switch_drive, 8'h20);
      check("shift kept", i_oss_switch_ctrl.lk.shift_word, 8'h20);
      check("oe deselected", {7'h00, serial_data_oe}, 8'h00);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      mismatches = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      enable_in = 1'b1;
      direct_cmd_five = 1'b0;
      direct_cmd_six = 1'b0;
      load_fault = 8'h00;
      t_reset();
      t_frame();
      t_persist();
      t_enable();
      t_direct();
      t_noise();
      finish_test();
   end
endmodule
`default_nettype wire
